// ===== src/rbr_dev_end.sv
// decoder end: block buffer, sync engine, serial readout and settings
// Behaviour
// RQ1: units of 32 bits, readable back to back
// RQ2: empty buffer shifts out all-zero units
// RQ3: interrupted unit rereads; last-bit-only means consumed
// RQ4: check bits never shifted out
// RQ5: header other than 1010 aborts read
// RQ6: offset_found flag carried; host ignores it
// RQ7: offset_code encodes A..E as 0..5
// RQ8: ram_next_avail set when another block waits
// RQ9: fill level encodes remaining stored blocks
// RQ10: traffic_id_detect reports traffic tone
// RQ11: sync_flag at receipt; pin shows present
// RQ12: err_count 0..5, 6 uncorrectable
// RQ13: over correct_limit reports uncorrectable
// RQ14: rds_word MSB first, raw if uncorrectable
// RQ15: host writes reserved bits as zero
// RQ16: loss_criterion picks order or uncorrectable count
// RQ17: loss_count_sel threshold table, reset gives 5
// RQ18: acquire on 2 of 3 or 2 consecutive
// RQ19: clear holds unsync, then backward-protection write
// RQ20: host clears by setting or pin pulse
// RQ21: host clears after each retune
// RQ22: async_write_enable also stores unsynchronized blocks
// RQ23: settings take initial values at reset
`timescale 1ns/1ps
module rbr_dev_end import rbr_pkg::*; #(
	parameter int DEPTH = BUF_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// link
	rbr_link_if.dev link,
	// decoder blocks
	input wire logic blk_valid,
	input wire logic [15:0] blk_word,
	input wire logic blk_offset_found,
	input wire logic [2:0] blk_offset_code,
	input wire logic blk_order_ok,
	input wire logic [2:0] blk_err_bits,
	input wire logic traffic_tone
);
	typedef enum logic [2:0] {L_IDLE, L_HDR, L_READ, L_WRITE, L_SKIP} rbr_lnk_e;
	localparam int PW = $clog2(DEPTH + 1);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [PW-1:0] wrap_add(input logic [PW-1:0] a, input logic [PW:0] b);
		logic [PW+1:0] s;
		s = {2'b00, a} + {1'b0, b};
		if (s >= (PW+2)'(DEPTH)) begin
			s = s - (PW+2)'(DEPTH);
		end
		return s[PW-1:0];
	endfunction

	function automatic logic [4:0] loss_thr(input logic [2:0] sel);
		case (sel)
			3'h0: return 5'h03;
			3'h1: return 5'h04;
			3'h2: return 5'h05;
			3'h3: return 5'h06;
			3'h4: return 5'h08;
			3'h5: return 5'h0a;
			3'h6: return 5'h0c;
			default: return 5'h10;
		endcase
	endfunction

	function automatic logic [1:0] fill_enc(input logic [PW-1:0] n);
		if (n >= PW'(24)) return 2'h3;
		if (n >= PW'(16)) return 2'h2;
		if (n >= PW'(8)) return 2'h1;
		return 2'h0;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] pins_s;
	logic lclk_d_reg;
	logic rise;
	logic fall;

	rbr_sync2 #(.W(4)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d({link.link_clk, link.link_sel, link.link_din, link.sync_clear_pin}),
		.q(pins_s)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lclk_d_reg <= 1'b0;
		end else if (clk_en) begin
			lclk_d_reg <= pins_s[3];
		end
	end

	assign rise = pins_s[3] & ~lclk_d_reg & pins_s[2];
	assign fall = ~pins_s[3] & lclk_d_reg & pins_s[2];

	// ---------------------------------------------------------------
	// settings and block classification
	// ---------------------------------------------------------------
	logic [11:0] set_reg;
	logic [2:0] err_rep;
	logic clear_act;
	logic synced_reg;
	logic [1:0] hist_reg;
	logic [4:0] loss_reg;
	logic acquire;
	logic bad;
	logic [1:0] ok_sum;

	// sync pin or setting, either one clears
	assign clear_act = set_reg[SET_CLEAR] | pins_s[0];
	// RQ13: limit forces uncorrectable
	assign err_rep = (blk_err_bits >= ERR_UNCORR || blk_err_bits > set_reg[SET_CLIM +: 3]) ?
		ERR_UNCORR : blk_err_bits;
	assign ok_sum = {1'b0, blk_order_ok} + {1'b0, hist_reg[0]} + {1'b0, hist_reg[1]};
	// RQ18: acquisition rule select
	assign acquire = set_reg[SET_ACQ_RULE] ? (blk_order_ok & hist_reg[0]) : (ok_sum >= 2'd2);
	// RQ16: loss criterion select
	assign bad = set_reg[SET_LOSS_CRIT] ? (err_rep == ERR_UNCORR) : ~blk_order_ok;

	// ---------------------------------------------------------------
	// sync engine
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			synced_reg <= 1'b0;
			hist_reg <= 2'b00;
			loss_reg <= 5'h00;
		end else if (clk_en) begin
			if (clear_act) begin
				// RQ19: held unsynchronized
				synced_reg <= 1'b0;
				hist_reg <= 2'b00;
				loss_reg <= 5'h00;
			end else if (blk_valid) begin
				hist_reg <= {hist_reg[0], blk_order_ok};
				loss_reg <= bad ? loss_reg + 5'h01 : 5'h00;
				if (!synced_reg && acquire) begin
					synced_reg <= 1'b1;
					loss_reg <= 5'h00;
				end else if (synced_reg && bad &&
					loss_reg + 5'h01 >= loss_thr(set_reg[SET_LOSS_SEL +: 3])) begin
					// RQ17: consecutive-block threshold
					synced_reg <= 1'b0;
					hist_reg <= 2'b00;
				end
			end
		end
	end

	// RQ11: pin tracks present state
	assign link.sync_now = synced_reg;

	// ---------------------------------------------------------------
	// block buffer
	// ---------------------------------------------------------------
	logic [24:0] mem [DEPTH];
	logic [PW-1:0] rd_ptr_reg;
	logic [PW-1:0] cnt_reg;
	logic [1:0] pend_reg;
	logic push;
	logic commit;
	logic roll;
	logic pop;
	logic [PW-1:0] wr_pos;

	assign push = blk_valid & ~clear_act & (32'(cnt_reg) + 32'(pend_reg) < DEPTH);
	// RQ22: store gating by sync and setting
	assign commit = synced_reg | set_reg[SET_ASYNC_WR] | acquire;
	assign roll = ~commit & (32'(pend_reg) == BP_MAX);
	assign wr_pos = roll ? wrap_add(rd_ptr_reg, {1'b0, cnt_reg}) :
		wrap_add(rd_ptr_reg, {1'b0, cnt_reg} + {{(PW-1){1'b0}}, pend_reg});

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			// RQ4: check bits are never stored
			mem[wr_pos] <= {blk_word, blk_offset_found, blk_offset_code, traffic_tone,
				synced_reg, err_rep};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			pend_reg <= 2'b00;
		end else if (clk_en) begin
			if (clear_act) begin
				rd_ptr_reg <= '0;
				cnt_reg <= '0;
				pend_reg <= 2'b00;
			end else begin
				if (pop) begin
					rd_ptr_reg <= wrap_add(rd_ptr_reg, (PW+1)'(1));
				end
				if (push && commit) begin
					// RQ19: backward-protection blocks committed
					cnt_reg <= cnt_reg + PW'(pend_reg) + PW'(1) - PW'(pop);
					pend_reg <= 2'b00;
				end else begin
					cnt_reg <= cnt_reg - PW'(pop);
					if (push) begin
						pend_reg <= roll ? 2'b01 : pend_reg + 2'b01;
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// readout unit
	// ---------------------------------------------------------------
	logic [24:0] head;
	logic [PW-1:0] rem;
	logic [31:0] unit;

	assign head = mem[rd_ptr_reg];
	assign rem = cnt_reg - PW'(1);

	always_comb begin
		unit = '0;
		if (cnt_reg != '0) begin
			// RQ14: word sent msb first
			unit[U_WORD +: 16] = head[24:9];
			// RQ6: offset_found carried as flag
			unit[U_FOUND] = head[8];
			// RQ7: offset_code field
			unit[U_CODE +: 3] = head[7:5];
			// RQ8: another block waits
			unit[U_NEXT] = (rem != '0);
			// RQ9: remaining block level
			unit[U_FILL +: 2] = fill_enc(rem);
			// RQ10: traffic tone flag
			unit[U_TRAF] = head[4];
			// RQ11: sync at receipt
			unit[U_SYNC] = head[3];
			// RQ12: corrected bit count
			unit[U_ERR +: 3] = head[2:0];
		end
	end

	// ---------------------------------------------------------------
	// link framing
	// ---------------------------------------------------------------
	rbr_lnk_e st_reg;
	logic [4:0] bcnt_reg;
	logic [2:0] hdr_reg;
	logic [31:0] sh_reg;
	logic real_reg;
	logic [11:0] wsh_reg;
	logic dout_reg;

	assign pop = (st_reg == L_READ) & rise & (bcnt_reg == 5'd30) & real_reg & (cnt_reg != '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= L_IDLE;
			bcnt_reg <= 5'd0;
			hdr_reg <= 3'h0;
			sh_reg <= '0;
			real_reg <= 1'b0;
			wsh_reg <= '0;
			dout_reg <= 1'b0;
		end else if (clk_en) begin
			if (!pins_s[2]) begin
				st_reg <= L_IDLE;
				dout_reg <= 1'b0;
			end else begin
				case (st_reg)
					L_IDLE: begin
						st_reg <= L_HDR;
						bcnt_reg <= 5'd0;
					end
					L_HDR: if (rise) begin
						hdr_reg <= {hdr_reg[1:0], pins_s[1]};
						bcnt_reg <= bcnt_reg + 5'd1;
						if (bcnt_reg == 5'(HDR_W - 1)) begin
							bcnt_reg <= 5'd0;
							if ({hdr_reg, pins_s[1]} == HDR_READ) begin
								st_reg <= L_READ;
								sh_reg <= unit;
								real_reg <= (cnt_reg != '0);
							end else if ({hdr_reg, pins_s[1]} == HDR_WRITE) begin
								st_reg <= L_WRITE;
							end else begin
								// RQ5: bad header aborts read
								st_reg <= L_SKIP;
							end
						end
					end
					L_READ: begin
						if (rise) begin
							// RQ3: consumed once 31 bits read
							if (bcnt_reg == 5'd31) begin
								// RQ1: next unit back to back
								bcnt_reg <= 5'd0;
								sh_reg <= unit;
								// RQ2: empty gives zero unit
								real_reg <= (cnt_reg != '0);
							end else begin
								bcnt_reg <= bcnt_reg + 5'd1;
							end
						end else if (fall) begin
							dout_reg <= sh_reg[31];
							sh_reg <= {sh_reg[30:0], 1'b0};
						end
					end
					L_WRITE: if (rise) begin
						wsh_reg <= {pins_s[1], wsh_reg[11:1]};
						bcnt_reg <= bcnt_reg + 5'd1;
						if (bcnt_reg == 5'(SET_W - 1)) begin
							st_reg <= L_SKIP;
						end
					end
					L_SKIP: st_reg <= L_SKIP;
					default: st_reg <= L_IDLE;
				endcase
			end
		end
	end

	assign link.link_dout = dout_reg;

	// ---------------------------------------------------------------
	// settings register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// RQ23: initial settings
			set_reg <= SET_RST;
		end else if (clk_en && st_reg == L_WRITE && rise && bcnt_reg == 5'(SET_W - 1)) begin
			set_reg <= {pins_s[1], wsh_reg[11:1]} & SET_USED;
		end
	end
endmodule // rbr_dev_end

// ===== src/rbr_host_end.sv
// controller end: register port, clock divider and frame shifter
`timescale 1ns/1ps
module rbr_host_end import rbr_pkg::*; #(
	parameter int HALF = HALF_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// link
	rbr_link_if.host link
);
	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} rbr_hst_e;

	function automatic logic [11:0] rev12(input logic [11:0] v);
		logic [11:0] r;
		r = '0;
		for (int i = 0; i < 12; i++) begin
			r[i] = v[11-i];
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	rbr_hst_e st_reg;
	logic [11:0] set_reg;
	logic [31:0] unit_reg;
	logic new_reg;
	logic [5:0] clr_reg;
	logic [1:0] pin_s;
	logic go_rd;
	logic go_wr;
	logic done;

	rbr_sync2 #(.W(2)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d({link.link_dout, link.sync_now}),
		.q(pin_s)
	);

	assign go_rd = wr && addr == REG_CTRL && wdata[0] && st_reg == H_IDLE;
	assign go_wr = wr && addr == REG_CTRL && wdata[1] && !wdata[0] && st_reg == H_IDLE;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			set_reg <= SET_RST;
			new_reg <= 1'b0;
			clr_reg <= 6'd0;
			rdata <= '0;
		end else if (clk_en) begin
			if (wr && addr == REG_SET) begin
				// RQ15: reserved bits forced zero
				set_reg <= wdata[11:0] & SET_USED;
			end
			// RQ20: pin pulse over 250 ns; RQ21: used after retune
			if (wr && addr == REG_CTRL && wdata[2] && clr_reg == 6'd0) begin
				clr_reg <= 6'(CLR_CYC);
			end else if (clr_reg != 6'd0) begin
				clr_reg <= clr_reg - 6'd1;
			end
			// a finishing read sets the flag even while software clears it
			if (done) begin
				new_reg <= 1'b1;
			end else if (rd && addr == REG_UNIT) begin
				new_reg <= 1'b0;
			end
			rdata <= '0;
			if (rd) begin
				case (addr)
					REG_SET: rdata <= {20'h0, set_reg};
					REG_STAT: rdata <= {28'h0, clr_reg != 6'd0, pin_s[0], new_reg,
						st_reg != H_IDLE};
					// RQ6: unit passed through unexamined
					REG_UNIT: rdata <= unit_reg;
					default: rdata <= '0;
				endcase
			end
		end
	end

	assign link.sync_clear_pin = (clr_reg != 6'd0);

	// ---------------------------------------------------------------
	// frame shifter
	// ---------------------------------------------------------------
	logic [35:0] tx_reg;
	logic [5:0] idx_reg;
	logic [5:0] nbits_reg;
	logic [7:0] ph_reg;
	logic rdmode_reg;
	logic lclk_reg;
	logic sel_reg;
	logic [31:0] rx_reg;

	assign done = (st_reg == H_END) && (ph_reg == 8'(HALF - 1)) && rdmode_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= H_IDLE;
			tx_reg <= '0;
			idx_reg <= 6'd0;
			nbits_reg <= 6'd0;
			ph_reg <= 8'd0;
			rdmode_reg <= 1'b0;
			lclk_reg <= 1'b0;
			sel_reg <= 1'b0;
			rx_reg <= '0;
			unit_reg <= '0;
		end else if (clk_en) begin
			case (st_reg)
				H_IDLE: if (go_rd || go_wr) begin
					tx_reg <= go_rd ? {HDR_READ, 32'h0} : {HDR_WRITE, rev12(set_reg), 20'h0};
					nbits_reg <= go_rd ? 6'(HDR_W + UNIT_W) : 6'(HDR_W + SET_W);
					rdmode_reg <= go_rd;
					idx_reg <= 6'd0;
					ph_reg <= 8'd0;
					sel_reg <= 1'b1;
					st_reg <= H_LOW;
				end
				H_LOW: begin
					ph_reg <= ph_reg + 8'd1;
					if (ph_reg == 8'(HALF - 1)) begin
						ph_reg <= 8'd0;
						lclk_reg <= 1'b1;
						st_reg <= H_HIGH;
					end
				end
				H_HIGH: begin
					ph_reg <= ph_reg + 8'd1;
					if (ph_reg == 8'(HALF - 1)) begin
						ph_reg <= 8'd0;
						lclk_reg <= 1'b0;
						tx_reg <= {tx_reg[34:0], 1'b0};
						idx_reg <= idx_reg + 6'd1;
						if (idx_reg >= 6'(HDR_W)) begin
							rx_reg <= {rx_reg[30:0], pin_s[1]};
						end
						st_reg <= (idx_reg == nbits_reg - 6'd1) ? H_END : H_LOW;
					end
				end
				H_END: begin
					ph_reg <= ph_reg + 8'd1;
					if (ph_reg == 8'(HALF - 1)) begin
						sel_reg <= 1'b0;
						if (rdmode_reg) begin
							unit_reg <= rx_reg;
						end
						st_reg <= H_IDLE;
					end
				end
				default: st_reg <= H_IDLE;
			endcase
		end
	end

	assign link.link_clk = lclk_reg;
	assign link.link_sel = sel_reg;
	assign link.link_din = tx_reg[35];
endmodule // rbr_host_end

// ===== src/rbr_link_if.sv
// four-wire serial link plus sync clear and sync state pins between controller and decoder
`timescale 1ns/1ps
interface rbr_link_if;
	logic link_clk;
	logic link_sel;
	logic link_din;
	logic link_dout;
	logic sync_clear_pin;
	logic sync_now;
	modport dev(input link_clk, input link_sel, input link_din, input sync_clear_pin,
		output link_dout, output sync_now);
	modport host(output link_clk, output link_sel, output link_din, output sync_clear_pin,
		input link_dout, input sync_now);
endinterface

// ===== src/rbr_pkg.sv
// shared constants of the radio data readout link
package rbr_pkg;
	// ---------------------------------------------------------------
	// frame layout
	// ---------------------------------------------------------------
	localparam int HDR_W = 4;
	localparam int UNIT_W = 32;
	localparam int SET_W = 12;
	localparam logic [3:0] HDR_READ = 4'ha;
	localparam logic [3:0] HDR_WRITE = 4'h6;
	// ---------------------------------------------------------------
	// settings word, first bit shifted is bit 0
	// ---------------------------------------------------------------
	localparam int SET_LOSS_SEL = 0;
	localparam int SET_LOSS_CRIT = 3;
	localparam int SET_ACQ_RULE = 4;
	localparam int SET_CLEAR = 5;
	localparam int SET_ASYNC_WR = 6;
	localparam int SET_CLIM = 7;
	localparam logic [11:0] SET_RST = 12'h102;
	localparam logic [11:0] SET_USED = 12'h3ff;
	// ---------------------------------------------------------------
	// readout unit fields
	// ---------------------------------------------------------------
	localparam int U_WORD = 16;
	localparam int U_FOUND = 15;
	localparam int U_CODE = 12;
	localparam int U_NEXT = 11;
	localparam int U_FILL = 9;
	localparam int U_TRAF = 8;
	localparam int U_SYNC = 7;
	localparam int U_ERR = 4;
	localparam logic [2:0] ERR_UNCORR = 3'h6;
	// ---------------------------------------------------------------
	// buffer and timing
	// ---------------------------------------------------------------
	localparam int BUF_DEPTH = 24;
	localparam int BP_MAX = 3;
	localparam int CLK_NS = 8;
	localparam int CLR_NS = 250;
	localparam int CLR_CYC = (CLR_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int HALF_CYC = 8;
	// ---------------------------------------------------------------
	// host register map
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_SET = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;
	localparam logic [3:0] REG_UNIT = 4'hc;
endpackage

// ===== src/rbr_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rbr_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else if (clk_en) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // rbr_sync2

// ===== verification/rbr_link_asserts.sv
// link protocol checker placed beside the link interface
`timescale 1ns/1ps
module rbr_link_asserts import rbr_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link wires
	input wire logic link_clk,
	input wire logic link_sel,
	input wire logic link_din,
	input wire logic link_dout,
	input wire logic sync_clear_pin,
	input wire logic sync_now
);
	logic clk_d_reg;
	logic [7:0] rise_reg;
	logic [7:0] clr_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_d_reg <= 1'b0;
		end else begin
			clk_d_reg <= link_clk;
		end
	end
	// rises in the current frame, cleared between frames
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_reg <= 8'h0;
		end else begin
			rise_reg <= !link_sel ? 8'h0 : rise_reg + {7'h0, link_clk & ~clk_d_reg};
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_reg <= 8'h0;
		end else begin
			clr_reg <= sync_clear_pin ? clr_reg + 8'h1 : 8'h0;
		end
	end
	sequence s_high_half;
		link_clk [*8] ##1 !link_clk;
	endsequence
	sequence s_clear_held;
		sync_clear_pin [*8];
	endsequence
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	AST_CLK_IDLE: assert property (!link_sel |-> !link_clk)
		else $error("link clock moves outside a frame");
	AST_CLK_HIGH: assert property ($rose(link_clk) |-> s_high_half)
		else $error("link clock high time wrong");
	AST_DIN_STABLE: assert property (link_clk && $past(link_clk) |-> $stable(link_din))
		else $error("host data moved while clock high");
	AST_HDR_THIRD: assert property ($rose(link_clk) && link_sel && rise_reg == 8'h2 |-> link_din)
		else $error("third header bit not one");
	AST_HDR_FOURTH: assert property ($rose(link_clk) && link_sel && rise_reg == 8'h3 |-> !link_din)
		else $error("fourth header bit not zero");
	AST_DOUT_HDR: assert property (link_sel && rise_reg < 8'h4 |-> !link_dout)
		else $error("device data during header");
	AST_DOUT_IDLE: assert property (!link_sel [*4] |-> !link_dout)
		else $error("device data outside a frame");
	AST_FRAME_LEN: assert property ($fell(link_sel) |-> rise_reg == 8'h24 || rise_reg == 8'h10)
		else $error("frame clock count wrong");
	AST_CLR_WIDTH: assert property ($fell(sync_clear_pin) |-> clr_reg == 8'(CLR_CYC))
		else $error("clear pulse width wrong");
	AST_CLEAR_UNSYNC: assert property (s_clear_held |-> !sync_now)
		else $error("synchronized while clear held");
endmodule // rbr_link_asserts

// ===== verification/rds_block_readout_sync_control_bench.sv
// self-checking bench joining host end and decoder end over the link
`timescale 1ns/1ps
module rds_block_readout_sync_control_bench import rbr_pkg::*;;
	logic clk;
	logic rst_n;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic blk_valid;
	logic [15:0] blk_word;
	logic blk_offset_found;
	logic [2:0] blk_offset_code;
	logic blk_order_ok;
	logic [2:0] blk_err_bits;
	logic traffic_tone;
	int n_fail;
	int compares;
	logic [2:0] err_in [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
	logic [2:0] err_out [6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h6, 3'h6};
	rbr_link_if lnk();
	rbr_host_end #(.HALF(8)) u_rbr_host_end (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(lnk));
	rbr_dev_end #(.DEPTH(BUF_DEPTH)) u_rbr_dev_end (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.link(lnk), .blk_valid(blk_valid), .blk_word(blk_word),
		.blk_offset_found(blk_offset_found), .blk_offset_code(blk_offset_code),
		.blk_order_ok(blk_order_ok), .blk_err_bits(blk_err_bits), .traffic_tone(traffic_tone));
	rbr_link_asserts u_rbr_link_asserts (.clk(clk), .rst_n(rst_n), .link_clk(lnk.link_clk),
		.link_sel(lnk.link_sel), .link_din(lnk.link_din), .link_dout(lnk.link_dout),
		.sync_clear_pin(lnk.sync_clear_pin), .sync_now(lnk.sync_now));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] got);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	// bounded poll: a stuck frame shows up as a busy mismatch
	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h1;
		for (int i = 0; i < 1000 && s[0] !== 1'b0; i++) rd_reg(REG_STAT, s);
		chk("busy", 32'h0, {31'h0, s[0]});
	endtask
	task automatic read_unit(output logic [31:0] u);
		wr_reg(REG_CTRL, 32'h1);
		wait_idle();
		rd_reg(REG_UNIT, u);
	endtask
	task automatic set_cfg(input logic [31:0] v);
		wr_reg(REG_SET, v);
		wr_reg(REG_CTRL, 32'h2);
		wait_idle();
	endtask
	task automatic send(input logic [15:0] w, input logic ok, input logic [2:0] c,
		input logic [2:0] e, input logic t);
		@(posedge clk);
		blk_valid <= 1'b1;
		{blk_word, blk_order_ok, blk_offset_code, blk_err_bits, traffic_tone} <= {w, ok, c, e, t};
		@(posedge clk);
		blk_valid <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic chk_sync(input logic exp);
		logic [31:0] s;
		rd_reg(REG_STAT, s);
		chk("sync_now", {31'h0, exp}, {31'h0, s[2]});
	endtask
	function automatic logic [31:0] unit(input logic [15:0] w, input logic [2:0] c,
		input logic nx, input logic t, input logic s, input logic [2:0] e);
		return {w, 1'b1, c, nx, 2'b00, t, s, e, 4'h0};
	endfunction
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] v;
		rd_reg(REG_SET, v);
		chk("settings", 32'h102, v);
		chk_sync(1'b0);
		read_unit(v);
		chk("empty unit", 32'h0, v);
		wr_reg(REG_SET, 32'hfff);
		rd_reg(REG_SET, v);
		chk("reserved", 32'h3ff, v);
		set_cfg(32'h102);
	endtask
	// first block is backward protection, second acquires; both read back unsynchronized before the synced ones
	task automatic t_acquire();
		logic [31:0] v;
		logic [31:0] x;
		for (int i = 0; i < 6; i++) begin
			send(16'h9c30 + 16'(i), 1'b1, i[2:0], err_in[i], i[0]);
			chk_sync(i > 0);
		end
		for (int i = 0; i < 6; i++) begin
			read_unit(v);
			x = unit(16'h9c30 + 16'(i), i[2:0], i < 5, i[0], i > 1, err_out[i]);
			chk("unit", x, v);
		end
		read_unit(v);
		chk("drained", 32'h0, v);
	endtask
	task automatic t_loss();
		logic [31:0] v;
		set_cfg(32'h100);
		for (int i = 0; i < 3; i++) begin
			send(16'h0f0f, 1'b0, 3'h1, 3'h0, 1'b0);
			chk_sync(i < 2);
		end
		// uncorrectable count: three order misses alone must not drop sync
		set_cfg(32'h108);
		for (int i = 0; i < 8; i++) begin
			send(16'h0f10, i < 2 || i > 4, 3'h2, i > 4 ? 3'h6 : 3'h0, 1'b0);
			chk_sync(i > 0 && i < 7);
		end
		// eleven stored: ten remain behind the head, next set and level 8 to 15
		read_unit(v);
		chk("fill level", 32'h5, {29'h0, v[U_FILL +: 3]});
	endtask
	task automatic t_clear();
		logic [31:0] v;
		// regain sync first so the held-unsynchronized check has teeth
		send(16'h2a00, 1'b1, 3'h0, 3'h0, 1'b0);
		send(16'h2a01, 1'b1, 3'h1, 3'h0, 1'b0);
		chk_sync(1'b1);
		wr_reg(REG_CTRL, 32'h4);
		rd_reg(REG_STAT, v);
		chk("clear pin", 32'h1, {31'h0, v[3]});
		repeat (40) @(posedge clk);
		chk_sync(1'b0);
		read_unit(v);
		chk("cleared", 32'h0, v);
		set_cfg(32'h112);
		send(16'h1234, 1'b1, 3'h0, 3'h0, 1'b0);
		send(16'h1235, 1'b0, 3'h1, 3'h0, 1'b0);
		send(16'h1236, 1'b1, 3'h2, 3'h0, 1'b0);
		chk_sync(1'b0);
		set_cfg(32'h102);
		send(16'h1237, 1'b0, 3'h3, 3'h0, 1'b0);
		send(16'h1238, 1'b1, 3'h4, 3'h0, 1'b0);
		chk_sync(1'b1);
	endtask
	task automatic t_async();
		logic [31:0] v;
		set_cfg(32'h122);
		send(16'h7e80, 1'b1, 3'h2, 3'h0, 1'b0);
		chk_sync(1'b0);
		set_cfg(32'h142);
		read_unit(v);
		chk("flushed", 32'h0, v);
		send(16'h7e81, 1'b0, 3'h4, 3'h0, 1'b0);
		read_unit(v);
		chk("async unit", unit(16'h7e81, 3'h4, 1'b0, 1'b0, 1'b0, 3'h0), v);
	endtask
	// ---------------------------------------------------------------
	// run control
	// ---------------------------------------------------------------
	task automatic report_and_stop();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// tests need about 9300 cycles
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
	initial begin
		n_fail = 0;
		compares = 0;
		rst_n = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		blk_valid = 1'b0;
		blk_word = 16'h0;
		blk_offset_found = 1'b1;
		blk_offset_code = 3'h0;
		blk_order_ok = 1'b0;
		blk_err_bits = 3'h0;
		traffic_tone = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_acquire();
		t_loss();
		t_clear();
		t_async();
		report_and_stop();
	end
endmodule // rds_block_readout_sync_control_bench
